// file: shared/alarm_irq_pkg.sv
// Purpose: constants and types for the E1 alarm and error interrupt enable block
// Assumes: Avalon-MM slave, 32-bit data, byte addresses, one clock
// Notes: the enable register doubles as the interrupt mask
package alarm_irq_pkg;

    // ----------------------------------------
    // register map, byte addresses
    // ----------------------------------------
    localparam int ADDR_W = 5;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 5'h00;
    localparam logic [ADDR_W-1:0] ENABLE_OFS = 5'h04;
    localparam logic [ADDR_W-1:0] FRAMING_OFS = 5'h08;
    localparam logic [ADDR_W-1:0] LINE_STATE_OFS = 5'h0c;

    // ----------------------------------------
    // field positions
    // ----------------------------------------
    localparam int FAR_ALARM_BIT = 7;
    localparam int MF_CHANGE_BIT = 5;
    localparam int KEEP_ZERO_BIT = 4;
    localparam int LCV_BIT = 3;
    localparam int OOF_CHANGE_BIT = 2;
    localparam int THR_W = 3;
    localparam int LS_FAR_BIT = 0;
    localparam int LS_OOF_BIT = 1;
    localparam int LS_MF_BIT = 2;

    // ----------------------------------------
    // masks and reset values
    // ----------------------------------------
    localparam logic [7:0] ENABLE_RW_MASK = 8'h3c;
    localparam logic [7:0] STATUS_MASK = 8'h2c;
    localparam logic [7:0] ENABLE_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [THR_W-1:0] THRESHOLD_RESET = 3'h3;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // ----------------------------------------
    // carriers
    // ----------------------------------------
    typedef struct packed {
        logic read;
        logic write;
        logic [ADDR_W-1:0] address;
        logic [31:0] writedata;
    } avs_req_t;

    typedef struct packed {
        logic nfas_strobe;
        logic a_bit;
        logic fas_strobe;
        logic fas_errored;
        logic lcv_strobe;
        logic mf_yellow;
    } line_ev_t;

endpackage : alarm_irq_pkg

// file: core/far_alarm_detect.sv
// Purpose: far-end alarm state from the A bit of non-FAS frames
// Assumes: one strobe per non-FAS frame, A bit valid with it
// Notes: two equal A bits in a row move the state
`timescale 1ns/1ps
module far_alarm_detect
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // non-FAS frame
    input wire logic i_nfas_strobe,
    input wire logic i_a_bit,
    // state
    output logic o_far_alarm
);

    logic last_a_reg;
    logic last_valid_reg;
    logic far_reg;

    // ----------------------------------------
    // last A bit seen
    // ----------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            last_a_reg <= 1'b0;
            last_valid_reg <= 1'b0;
        end
        else if (i_nfas_strobe)
        begin
            last_a_reg <= i_a_bit;
            last_valid_reg <= 1'b1;
        end
    end

    // ----------------------------------------
    // declare and clear
    // ----------------------------------------
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
        begin
            far_reg <= 1'b0;
        end
        else if (i_nfas_strobe && last_valid_reg && (last_a_reg == i_a_bit))
        begin
            far_reg <= i_a_bit;
        end
    end

    assign o_far_alarm = far_reg;

endmodule : far_alarm_detect

// file: core/alarm_error_irq_top.sv
// Purpose: alarm and error interrupt enable, status and request
// Assumes: line events synchronous to I_CLK, one-cycle strobes
// Notes: a bus access answers with waitrequest low on the second edge
//
// Local design decisions: register access over Avalon-MM and the register addresses.
`timescale 1ns/1ps
module alarm_error_irq_top
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // register bus
    input wire alarm_irq_pkg::avs_req_t i_AVS_REQ,
    output logic [31:0] o_AVS_READDATA,
    output logic o_AVS_WAITREQUEST,
    // line events from the framer
    input wire alarm_irq_pkg::line_ev_t i_LINE,
    // status outputs
    output logic o_FAR_ALARM,
    output logic o_OOF,
    output logic o_IRQ
);

    logic far_alarm;
    logic far_alarm_reg;
    logic [7:0] enable_reg;
    logic [7:0] status_reg;
    logic [7:0] status_next;
    logic [7:0] status_set;
    logic [7:0] status_clr;
    logic [alarm_irq_pkg::THR_W-1:0] frame_loss_threshold_reg;
    logic [alarm_irq_pkg::THR_W-1:0] fas_err_cnt_reg;
    logic [alarm_irq_pkg::THR_W-1:0] thr_eff;
    logic oof_reg;
    logic mf_last_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;
    logic irq_reg;
    logic req;
    logic accept;
    logic done;
    logic do_write;
    logic do_read;
    logic oof_declare;
    logic oof_clear;

    // ----------------------------------------
    // far-end alarm detector
    // ----------------------------------------
    far_alarm_detect u_far
    (
        .i_clk(I_CLK),
        .i_nrst(I_NRST),
        .i_nfas_strobe(i_LINE.nfas_strobe),
        .i_a_bit(i_LINE.a_bit),
        .o_far_alarm(far_alarm)
    );

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            far_alarm_reg <= 1'b0;
        end
        else
        begin
            far_alarm_reg <= far_alarm;
        end
    end

    // ----------------------------------------
    // bus handshake
    // ----------------------------------------
    assign req = i_AVS_REQ.read || i_AVS_REQ.write;
    assign accept = req && wait_reg;
    assign done = req && !wait_reg;
    assign do_write = done && i_AVS_REQ.write;
    assign do_read = done && i_AVS_REQ.read;

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            wait_reg <= 1'b1;
        end
        else
        begin
            wait_reg <= !accept;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            rdata_reg <= alarm_irq_pkg::READ_ZERO;
        end
        else if (accept && i_AVS_REQ.read)
        begin
            case (i_AVS_REQ.address)
                alarm_irq_pkg::STATUS_OFS:
                begin
                    rdata_reg <= {24'h00_0000, status_reg};
                end
                alarm_irq_pkg::ENABLE_OFS:
                begin
                    rdata_reg <= {24'h00_0000, far_alarm_reg,
                        enable_reg[6:0]};
                end
                alarm_irq_pkg::FRAMING_OFS:
                begin
                    rdata_reg <= {29'h0000_0000, frame_loss_threshold_reg};
                end
                alarm_irq_pkg::LINE_STATE_OFS:
                begin
                    rdata_reg <= {29'h0000_0000, mf_last_reg, oof_reg, far_alarm_reg};
                end
                default:
                begin
                    rdata_reg <= alarm_irq_pkg::READ_ZERO;
                end
            endcase
        end
    end

    // ----------------------------------------
    // enable and framing control registers
    // ----------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            enable_reg <= alarm_irq_pkg::ENABLE_RESET;
        end
        else if (do_write && i_AVS_REQ.address == alarm_irq_pkg::ENABLE_OFS)
        begin
            // bit 4 is stored only, software keeps it zero
            enable_reg <= i_AVS_REQ.writedata[7:0] & alarm_irq_pkg::ENABLE_RW_MASK;
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            frame_loss_threshold_reg <= alarm_irq_pkg::THRESHOLD_RESET;
        end
        else if (do_write && i_AVS_REQ.address == alarm_irq_pkg::FRAMING_OFS)
        begin
            frame_loss_threshold_reg <= i_AVS_REQ.writedata[alarm_irq_pkg::THR_W-1:0];
        end
    end

    // ----------------------------------------
    // out-of-frame state
    // ----------------------------------------
    assign thr_eff = (frame_loss_threshold_reg == '0) ? 3'h1 : frame_loss_threshold_reg;
    assign oof_declare = !oof_reg && i_LINE.fas_strobe && i_LINE.fas_errored
        && (fas_err_cnt_reg + 3'h1 >= thr_eff);
    assign oof_clear = oof_reg && i_LINE.fas_strobe && !i_LINE.fas_errored;

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            fas_err_cnt_reg <= '0;
        end
        else if (i_LINE.fas_strobe)
        begin
            if (!i_LINE.fas_errored || oof_declare)
            begin
                fas_err_cnt_reg <= '0;
            end
            else if (fas_err_cnt_reg != 3'h7)
            begin
                fas_err_cnt_reg <= fas_err_cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            oof_reg <= 1'b0;
        end
        else if (oof_declare)
        begin
            oof_reg <= 1'b1;
        end
        else if (oof_clear)
        begin
            oof_reg <= 1'b0;
        end
    end

    // ----------------------------------------
    // multiframe yellow edge memory
    // ----------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            mf_last_reg <= 1'b0;
        end
        else
        begin
            mf_last_reg <= i_LINE.mf_yellow;
        end
    end

    // ----------------------------------------
    // sticky status, set wins over clear
    // ----------------------------------------
    always_comb
    begin
        status_set = 8'h00;
        status_set[alarm_irq_pkg::MF_CHANGE_BIT] =
            enable_reg[alarm_irq_pkg::MF_CHANGE_BIT] && (mf_last_reg != i_LINE.mf_yellow);
        status_set[alarm_irq_pkg::LCV_BIT] =
            enable_reg[alarm_irq_pkg::LCV_BIT] && i_LINE.lcv_strobe;
        status_set[alarm_irq_pkg::OOF_CHANGE_BIT] =
            enable_reg[alarm_irq_pkg::OOF_CHANGE_BIT] && (oof_declare || oof_clear);
        status_clr = 8'h00;
        if (do_read && i_AVS_REQ.address == alarm_irq_pkg::STATUS_OFS)
        begin
            status_clr = rdata_reg[7:0];
        end
        if (do_write && i_AVS_REQ.address == alarm_irq_pkg::STATUS_OFS)
        begin
            status_clr = status_clr | i_AVS_REQ.writedata[7:0];
        end
        status_next = ((status_reg & ~status_clr) | status_set) & alarm_irq_pkg::STATUS_MASK;
    end

    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            status_reg <= alarm_irq_pkg::STATUS_RESET;
        end
        else
        begin
            status_reg <= status_next;
        end
    end

    // ----------------------------------------
    // interrupt request
    // ----------------------------------------
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            irq_reg <= 1'b0;
        end
        else
        begin
            irq_reg <= |(status_next & enable_reg);
        end
    end

    assign o_AVS_READDATA = rdata_reg;
    assign o_AVS_WAITREQUEST = wait_reg;
    assign o_FAR_ALARM = far_alarm_reg;
    assign o_OOF = oof_reg;
    assign o_IRQ = irq_reg;

endmodule : alarm_error_irq_top

// file: bench/alarm_irq_properties.sv
// Purpose: concurrent checks on the alarm and error interrupt block
// Assumes: bound to the top, one clock domain
// Notes: helper regs mirror enable, threshold and the last A bit
`timescale 1ns/1ps
module alarm_irq_properties
(
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // watched ports
    input wire alarm_irq_pkg::avs_req_t i_AVS_REQ,
    input wire logic [31:0] o_AVS_READDATA,
    input wire logic o_AVS_WAITREQUEST,
    input wire alarm_irq_pkg::line_ev_t i_LINE,
    input wire logic o_FAR_ALARM,
    input wire logic o_OOF,
    input wire logic o_IRQ
);
    logic [7:0] en_reg;
    logic [2:0] thr_reg;
    logic [3:0] err_reg;
    logic pa_reg;
    logic wr;
    assign wr = !o_AVS_WAITREQUEST && i_AVS_REQ.write;
    always_ff @(posedge I_CLK)
    begin
        if (!I_NRST)
        begin
            en_reg <= 8'h00;
            thr_reg <= 3'h3;
            err_reg <= 4'h0;
            pa_reg <= 1'b0;
        end
        else
        begin
            if (wr && i_AVS_REQ.address == alarm_irq_pkg::ENABLE_OFS)
                en_reg <= i_AVS_REQ.writedata[7:0];
            if (wr && i_AVS_REQ.address == alarm_irq_pkg::FRAMING_OFS)
                thr_reg <= i_AVS_REQ.writedata[2:0];
            if (i_LINE.fas_strobe)
                err_reg <= i_LINE.fas_errored ? err_reg + 4'h1 : 4'h0;
            if (i_LINE.nfas_strobe)
                pa_reg <= i_LINE.a_bit;
        end
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (!I_NRST);
    sequence s_answer;
        !o_AVS_WAITREQUEST ##1 o_AVS_WAITREQUEST;
    endsequence
    AST_WAIT_ONE: assert property ((i_AVS_REQ.read || i_AVS_REQ.write) && o_AVS_WAITREQUEST
        |=> s_answer) else $error("bus answer not one cycle");
    AST_FAR_SET: assert property (i_LINE.nfas_strobe && i_LINE.a_bit && pa_reg
        |-> ##2 o_FAR_ALARM) else $error("far alarm not declared");
    AST_FAR_CLR: assert property (i_LINE.nfas_strobe && !i_LINE.a_bit && !pa_reg
        |-> ##2 !o_FAR_ALARM) else $error("far alarm not cleared");
    AST_STATE_RO: assert property (!o_AVS_WAITREQUEST && i_AVS_REQ.read
        && i_AVS_REQ.address == alarm_irq_pkg::ENABLE_OFS
        |-> (o_AVS_READDATA[7] == o_FAR_ALARM || o_AVS_READDATA[7] == $past(o_FAR_ALARM))
        && o_AVS_READDATA[6] == 1'b0 && o_AVS_READDATA[1:0] == 2'h0)
        else $error("enable read wrong");
    AST_LCV_IRQ: assert property (i_LINE.lcv_strobe && en_reg[3] |=> o_IRQ)
        else $error("violation without irq");
    AST_MF_IRQ: assert property ($changed(i_LINE.mf_yellow) && en_reg[5]
        |-> ##[1:3] o_IRQ) else $error("mf change without irq");
    AST_OOF_DECL: assert property (i_LINE.fas_strobe && i_LINE.fas_errored
        && err_reg + 4'h1 >= {1'b0, thr_reg} + {3'h0, thr_reg == 3'h0} |=> o_OOF)
        else $error("oof not declared");
    AST_MASKED: assert property ((en_reg & 8'h2c) == 8'h00 [*2] |-> !o_IRQ)
        else $error("irq while all masked");
endmodule : alarm_irq_properties
bind alarm_error_irq_top alarm_irq_properties u_props (.I_CLK(I_CLK), .I_NRST(I_NRST),
    .i_AVS_REQ(i_AVS_REQ), .o_AVS_READDATA(o_AVS_READDATA),
    .o_AVS_WAITREQUEST(o_AVS_WAITREQUEST), .i_LINE(i_LINE), .o_FAR_ALARM(o_FAR_ALARM),
    .o_OOF(o_OOF), .o_IRQ(o_IRQ));

// file: bench/line_partner.sv
// Purpose: incoming E1 line seen through the receive framer
// Assumes: one frame every four cycles, FAS and non-FAS alternate
// Notes: qualified bits show the inverse outside their strobe
`timescale 1ns/1ps
module line_partner
(
    // clock and reset
    input wire logic i_clk,
    input wire logic i_nrst,
    // line conditions
    input wire logic i_a,
    input wire logic i_bad,
    input wire logic i_lcv,
    input wire logic i_mf,
    // framer events
    output alarm_irq_pkg::line_ev_t o_line
);
    logic [2:0] cnt_reg;
    always_ff @(posedge i_clk)
    begin
        if (!i_nrst)
            cnt_reg <= 3'h0;
        else
            cnt_reg <= cnt_reg + 3'h1;
    end
    always_comb
    begin
        o_line.fas_strobe = cnt_reg == 3'h0;
        o_line.nfas_strobe = cnt_reg == 3'h4;
        o_line.a_bit = o_line.nfas_strobe ? i_a : !i_a;
        o_line.fas_errored = o_line.fas_strobe ? i_bad : !i_bad;
        o_line.lcv_strobe = i_lcv;
        o_line.mf_yellow = i_mf;
    end
endmodule : line_partner

// file: bench/tb_top.sv
// Purpose: self-checking bench for the alarm and error interrupt block
// Assumes: line_partner feeds the line side
// Notes: seed fixed, random enables and events
`timescale 1ns/1ps
module tb_top;
    logic I_CLK = 1'b0;
    logic I_NRST = 1'b0;
    alarm_irq_pkg::avs_req_t req = '0;
    alarm_irq_pkg::line_ev_t line;
    logic [31:0] rdata;
    logic wait_req, far, oof, irq;
    logic a = 1'b0, bad = 1'b0, lcv = 1'b0, mf = 1'b0;
    logic [31:0] q;
    logic [7:0] en;
    logic [1:0] ev;
    logic [2:0] thr;
    int n_mismatch = 0;
    int checked = 0;
    always #5 I_CLK = !I_CLK;
    alarm_error_irq_top DUT (.I_CLK(I_CLK), .I_NRST(I_NRST), .i_AVS_REQ(req),
        .o_AVS_READDATA(rdata), .o_AVS_WAITREQUEST(wait_req), .i_LINE(line),
        .o_FAR_ALARM(far), .o_OOF(oof), .o_IRQ(irq));
    line_partner u_line (.i_clk(I_CLK), .i_nrst(I_NRST), .i_a(a), .i_bad(bad),
        .i_lcv(lcv), .i_mf(mf), .o_line(line));
    // ----
    // tasks
    // ----
    function logic [31:0] exp_st(input logic [7:0] e, input logic [1:0] v);
        return {24'h0, e & {2'h0, v[1], 1'b0, v[0], 3'h0}};
    endfunction : exp_st
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            $display("BAD %s exp %h got %h", nm, e, g);
            n_mismatch++;
        end
    endtask : chk
    task bus(input logic w, input logic [4:0] ad, input logic [31:0] d);
        @(posedge I_CLK);
        req <= '{read: !w, write: w, address: ad, writedata: d};
        // a hang is caught by the watchdog
        do
        begin
            @(posedge I_CLK);
        end
        while (wait_req !== 1'b0);
        q = rdata;
        req <= '0;
    endtask : bus
    task rd(input string nm, input logic [4:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0);
        chk(nm, e, q);
    endtask : rd
    task tally_and_finish;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    // ----
    // tests
    // ----
    initial
    begin
        #200us;
        n_mismatch++;
        tally_and_finish();
    end
    initial
    begin
        void'($urandom(32'h345c));
        repeat (5) @(posedge I_CLK);
        I_NRST <= 1'b1;
        rd("enable", alarm_irq_pkg::ENABLE_OFS, 32'h0);
        rd("status", alarm_irq_pkg::STATUS_OFS, 32'h0);
        rd("framing", alarm_irq_pkg::FRAMING_OFS, 32'h3);
        rd("unmapped", 5'h10, 32'h0);
        bus(1'b1, alarm_irq_pkg::ENABLE_OFS, 32'hef);
        rd("enable rw", alarm_irq_pkg::ENABLE_OFS, 32'h2c);
        bus(1'b1, alarm_irq_pkg::ENABLE_OFS, 32'h0);
        a <= 1'b1;
        repeat (40) @(posedge I_CLK);
        chk("far", 32'h1, {31'h0, far});
        rd("alarm bit", alarm_irq_pkg::ENABLE_OFS, 32'h80);
        rd("line state", alarm_irq_pkg::LINE_STATE_OFS, 32'h1);
        a <= 1'b0;
        repeat (40) @(posedge I_CLK);
        rd("alarm bit", alarm_irq_pkg::ENABLE_OFS, 32'h0);
        for (int i = 0; i < 8; i++)
        begin
            en = 8'($urandom) & 8'h2c;
            ev = 2'($urandom);
            if (i < 2)
                en = i ? 8'h2c : 8'h00;
            bus(1'b1, alarm_irq_pkg::ENABLE_OFS, {24'h0, en});
            lcv <= ev[0];
            mf <= mf ^ ev[1];
            @(posedge I_CLK);
            lcv <= 1'b0;
            repeat (3) @(posedge I_CLK);
            chk("irq", {31'h0, exp_st(en, ev) != 32'h0}, {31'h0, irq});
            rd("status", alarm_irq_pkg::STATUS_OFS, exp_st(en, ev));
            rd("status again", alarm_irq_pkg::STATUS_OFS, 32'h0);
            chk("irq clr", 32'h0, {31'h0, irq});
        end
        bus(1'b1, alarm_irq_pkg::ENABLE_OFS, 32'h08);
        lcv <= 1'b1;
        @(posedge I_CLK);
        lcv <= 1'b0;
        repeat (2) @(posedge I_CLK);
        chk("irq lcv", 32'h1, {31'h0, irq});
        bus(1'b1, alarm_irq_pkg::STATUS_OFS, 32'h08);
        rd("status w1c", alarm_irq_pkg::STATUS_OFS, 32'h0);
        chk("irq w1c", 32'h0, {31'h0, irq});
        thr = 3'($urandom_range(7, 1));
        bus(1'b1, alarm_irq_pkg::FRAMING_OFS, {29'h0, thr});
        bus(1'b1, alarm_irq_pkg::ENABLE_OFS, 32'h04);
        bad <= 1'b1;
        repeat (8 * thr + 12) @(posedge I_CLK);
        chk("oof", 32'h1, {31'h0, oof});
        chk("oof irq", 32'h1, {31'h0, irq});
        bad <= 1'b0;
        repeat (12) @(posedge I_CLK);
        chk("oof clr", 32'h0, {31'h0, oof});
        rd("status oof", alarm_irq_pkg::STATUS_OFS, 32'h04);
        tally_and_finish();
    end
endmodule : tb_top
